// ===== rtc_alarm_backup.sv
// alarm 0 comparison and backup mode selection of the real-time clock
// assumes a register front end that presents one access per cycle, and a
// timekeeper that pulses i_tick_1hz in the cycle the new bcd time is shown
`timescale 1ns/1ps
`include "rtc_alarm_regs.svh"

module rtc_alarm_backup
  import rtc_alarm_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire reg_req_s i_req,
  input wire rtc_time_s i_time,
  input wire logic i_tick_1hz,
  input wire supply_s i_supply,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_bus_enable,
  output logic o_mem_enable,
  output logic o_on_backup,
  output logic o_alarm_flag,
  output logic o_alarm_irq_b
);

  // ************************************************************
  // local constants
  // ************************************************************
  localparam logic [8:0] PULSE_LEN = 9'(`IRQ_PULSE_CYC); // pulse width in cycles
  localparam logic [3:0] IDX_NONE = 4'hf; // unmapped address
  localparam logic [3:0] IDX_INT = 4'h6; // interrupt control index
  localparam logic [3:0] IDX_CFG = 4'h7; // backup config index
  localparam logic [3:0] IDX_STAT = 4'h8; // status index

  // ************************************************************
  // address decode, shared by write and read paths
  // ************************************************************
  function automatic logic [3:0] reg_index(input logic [7:0] addr);
    logic [3:0] idx;
    idx = IDX_NONE;
    case (addr)
      `ADDR_ALM_SEC: idx = 4'h0;
      `ADDR_ALM_MIN: idx = 4'h1;
      `ADDR_ALM_HOUR: idx = 4'h2;
      `ADDR_ALM_DATE: idx = 4'h3;
      `ADDR_ALM_MONTH: idx = 4'h4;
      `ADDR_ALM_WDAY: idx = 4'h5;
      `ADDR_INT_CTRL: idx = IDX_INT;
      `ADDR_CONFIG: idx = IDX_CFG;
      `ADDR_STATUS: idx = IDX_STAT;
      default: idx = IDX_NONE;
    endcase
    return idx;
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  rtc_state_s state_q; // every flip-flop of the block
  rtc_state_s state_d; // next value of the above
  logic [5:0][7:0] cur_field; // live time, one byte per field
  logic [5:0][7:0] field_mask; // bcd mask per field
  logic [5:0] field_used; // field enable seen
  logic [5:0] field_hit; // field agrees or is disabled
  logic alarm_match; // all enabled fields agree
  logic alarm_allowed; // alarm may fire in this power state
  logic alarm_event; // one-cycle match on a time step
  logic legacy_mode; // switchover_select chosen
  logic serial_in_backup_disable; // second config bit
  logic backup_now; // supply has moved to the battery
  logic bus_now; // serial bus may answer
  logic mem_now; // nonvolatile memory reachable
  logic [3:0] wr_idx; // decoded write target
  logic [3:0] rd_idx; // decoded read target
  logic bus_wr; // accepted write
  logic bus_rd; // accepted read
  logic flag_clear; // host clears the alarm flag

  // ************************************************************
  // field compare units
  // ************************************************************
  // field order matches the compare register order
  always_comb begin
    cur_field[0] = i_time.seconds;
    cur_field[1] = i_time.minutes;
    cur_field[2] = i_time.hours;
    cur_field[3] = i_time.date;
    cur_field[4] = i_time.month;
    cur_field[5] = i_time.weekday;
    field_mask[0] = `MASK_SEC;
    field_mask[1] = `MASK_MIN;
    field_mask[2] = `MASK_HOUR;
    field_mask[3] = `MASK_DATE;
    field_mask[4] = `MASK_MONTH;
    field_mask[5] = `MASK_WDAY;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_field
      rtc_alarm_field u_field (
        .i_cmp(state_q.cmp[gi]),
        .i_cur(cur_field[gi]),
        .i_mask(field_mask[gi]),
        .o_used(field_used[gi]),
        .o_hit(field_hit[gi])
      );
    end
  endgenerate

  // ************************************************************
  // backup mode selection
  // ************************************************************
  // supply comparators decide, config bits only steer which ones count
  always_comb begin
    legacy_mode = state_q.cfg[`CFG_SWSEL_BIT];
    serial_in_backup_disable = state_q.cfg[`CFG_SERIAL_IN_BACKUP_DISABLE_BIT];
    // legacy switches when main drops under battery, standard at trip level
    if (legacy_mode) begin
      backup_now = i_supply.below_battery;
    end else begin
      backup_now = i_supply.below_trip;
    end
    // bus and memory gating per mode
    case ({serial_in_backup_disable, legacy_mode})
      2'b00: begin
        bus_now = !backup_now;
        mem_now = !backup_now;
      end
      2'b01: begin
        bus_now = 1'b1;
        mem_now = 1'b1;
      end
      2'b10: begin
        bus_now = !backup_now;
        mem_now = !backup_now;
      end
      2'b11: begin
        // main must beat the battery as well as the reset level
        bus_now = !i_supply.below_battery;
        mem_now = !i_supply.below_battery;
      end
      default: begin
        bus_now = 1'b0;
        mem_now = 1'b0;
      end
    endcase
    // low voltage reset overrides every mode setting
    if (i_supply.low_voltage_reset) begin
      bus_now = 1'b0;
      mem_now = 1'b0;
    end
  end

  // ************************************************************
  // alarm match
  // ************************************************************
  // checked on every time step, so a seconds field can match too;
  // an all-disabled alarm never fires, else it would hit every second
  always_comb begin
    alarm_match = (&field_hit) && (|field_used);
    // standard backup silences everything but timekeeping
    alarm_allowed = !(state_q.on_backup && !legacy_mode);
    // host loads compares first, so enabling cannot catch a half-written set
    alarm_event = i_tick_1hz && alarm_match && alarm_allowed
      && state_q.int_ctrl[`INT_ALM_EN_BIT];
  end

  // ************************************************************
  // register access
  // ************************************************************
  // a disabled bus neither stores nor answers, as if the pins were dead
  always_comb begin
    bus_wr = i_req.wr && state_q.bus_en;
    bus_rd = i_req.rd && state_q.bus_en && !i_req.wr;
    wr_idx = reg_index(i_req.addr);
    rd_idx = reg_index(i_req.addr);
    flag_clear = bus_wr && (wr_idx == IDX_STAT) && !i_req.wdata[`STAT_ALM_FLAG_BIT];
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    state_d = state_q;
    state_d.rvalid = 1'b0;
    // power state, registered so all users see one consistent view
    state_d.on_backup = backup_now;
    state_d.bus_en = bus_now;
    state_d.mem_en = mem_now;
    // writes
    if (bus_wr) begin
      if (wr_idx < IDX_INT) begin
        state_d.cmp[wr_idx[2:0]] = i_req.wdata;
      end else if (wr_idx == IDX_INT) begin
        state_d.int_ctrl = i_req.wdata;
      end else if (wr_idx == IDX_CFG) begin
        state_d.cfg = i_req.wdata[1:0];
      end else begin
        state_d.cfg = state_q.cfg; // status only clears the flag
      end
    end
    // reads, unmapped addresses and the unused bits of config and status answer zero
    if (bus_rd) begin
      state_d.rvalid = 1'b1;
      if (rd_idx < IDX_INT) begin
        state_d.rdata = state_q.cmp[rd_idx[2:0]];
      end else if (rd_idx == IDX_INT) begin
        state_d.rdata = state_q.int_ctrl;
      end else if (rd_idx == IDX_CFG) begin
        state_d.rdata = {6'h00, state_q.cfg};
      end else if (rd_idx == IDX_STAT) begin
        state_d.rdata = 8'h00;
        state_d.rdata[`STAT_ALM_FLAG_BIT] = state_q.flag;
      end else begin
        state_d.rdata = 8'h00;
      end
    end
    // flag: a match in the clearing cycle still lands
    if (flag_clear) begin
      state_d.flag = 1'b0;
    end
    if (alarm_event) begin
      state_d.flag = 1'b1;
    end
    // interrupt sequencer
    case (state_q.st)
      IRQ_IDLE: begin
        if (alarm_event) begin
          if (state_q.int_ctrl[`INT_PULSE_MODE_BIT]) begin
            state_d.st = IRQ_PULSE;
            state_d.cnt = PULSE_LEN;
          end else begin
            state_d.st = IRQ_HOLD;
          end
        end
      end
      IRQ_PULSE: begin
        // fixed width, then ready for the next periodic match
        if (state_q.cnt <= 9'h001) begin
          state_d.st = IRQ_IDLE;
          state_d.cnt = 9'h000;
        end else begin
          state_d.cnt = state_q.cnt - 9'h001;
        end
      end
      IRQ_HOLD: begin
        // one event stays asserted until the host clears the flag
        if (flag_clear && !alarm_event) begin
          state_d.st = IRQ_IDLE;
        end
      end
      default: begin
        state_d.st = IRQ_IDLE;
        state_d.cnt = 9'h000;
      end
    endcase
  end

  // ************************************************************
  // registers
  // ************************************************************
  // config resets to legacy switchover with bus in backup
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      state_q.cmp <= {6{`ALM_CMP_RST}};
      state_q.int_ctrl <= `INT_CTRL_RST;
      state_q.cfg <= `CONFIG_RST;
      state_q.flag <= `STATUS_RST;
      state_q.st <= IRQ_IDLE;
      state_q.cnt <= 9'h000;
      state_q.rdata <= 8'h00;
      state_q.rvalid <= 1'b0;
      state_q.on_backup <= 1'b0;
      state_q.bus_en <= 1'b0;
      state_q.mem_en <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_comb begin
    o_rdata = state_q.rdata;
    o_rvalid = state_q.rvalid;
    o_bus_enable = state_q.bus_en;
    o_mem_enable = state_q.mem_en;
    o_on_backup = state_q.on_backup;
    o_alarm_flag = state_q.flag;
    o_alarm_irq_b = (state_q.st == IRQ_IDLE);
  end

endmodule

// ===== rtc_alarm_regs.svh
// register offsets, field positions, reset values and timing counts of the alarm and backup block
// assumes a 25 MHz system clock and an 8-bit register port in front of it
`ifndef RTC_ALARM_REGS_SVH
`define RTC_ALARM_REGS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define ADDR_ALM_SEC 8'h08
`define ADDR_ALM_MIN 8'h09
`define ADDR_ALM_HOUR 8'h0a
`define ADDR_ALM_DATE 8'h0b
`define ADDR_ALM_MONTH 8'h0c
`define ADDR_ALM_WDAY 8'h0d
`define ADDR_INT_CTRL 8'h11
`define ADDR_CONFIG 8'h12
`define ADDR_STATUS 8'h13

// ************************************************************
// field positions
// ************************************************************
`define ALM_FIELD_EN_BIT 7
`define INT_ALM_EN_BIT 5
`define INT_PULSE_MODE_BIT 7
`define CFG_SWSEL_BIT 0
`define CFG_SERIAL_IN_BACKUP_DISABLE_BIT 1
`define STAT_ALM_FLAG_BIT 5

// ************************************************************
// bcd value masks below the field enable bit
// ************************************************************
`define MASK_SEC 8'h7f
`define MASK_MIN 8'h7f
`define MASK_HOUR 8'h3f
`define MASK_DATE 8'h3f
`define MASK_MONTH 8'h1f
`define MASK_WDAY 8'h07

// ************************************************************
// reset values
// ************************************************************
`define ALM_CMP_RST 8'h00
`define INT_CTRL_RST 8'h00
`define CONFIG_RST 2'h1
`define STATUS_RST 1'b0

// ************************************************************
// timing
// ************************************************************
`define CLK_FREQ_KHZ 25000
`define IRQ_PULSE_NS 10000
`define IRQ_PULSE_CYC ((`IRQ_PULSE_NS * `CLK_FREQ_KHZ) / 1000000)

`endif

// ===== rtc_alarm_pkg.sv
// types shared by the alarm and backup mode logic
// assumes rtc_alarm_regs.svh carries the numbers; this package holds only types
package rtc_alarm_pkg;

  // ************************************************************
  // carriers
  // ************************************************************
  // current time, all fields bcd
  typedef struct packed {
    logic [7:0] weekday;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } rtc_time_s;

  // one register access from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // supply comparator levels, all active high
  typedef struct packed {
    logic low_voltage_reset;
    logic below_trip;
    logic below_battery;
  } supply_s;

  // ************************************************************
  // interrupt output sequencer, gray along idle-pulse-hold
  // ************************************************************
  typedef enum logic [1:0] {
    IRQ_IDLE = 2'b00,
    IRQ_PULSE = 2'b01,
    IRQ_HOLD = 2'b11
  } irq_state_e;

  // whole state of the top module
  typedef struct packed {
    logic [5:0][7:0] cmp;
    logic [7:0] int_ctrl;
    logic [1:0] cfg;
    logic flag;
    irq_state_e st;
    logic [8:0] cnt;
    logic [7:0] rdata;
    logic rvalid;
    logic on_backup;
    logic bus_en;
    logic mem_en;
  } rtc_state_s;

endpackage

// ===== rtc_alarm_field.sv
// one alarm comparison field: field enable plus masked bcd compare
// assumes the caller feeds the live time field and the field's bcd mask
`timescale 1ns/1ps
`include "rtc_alarm_regs.svh"

module rtc_alarm_field
  import rtc_alarm_pkg::*;
(
  input wire logic [7:0] i_cmp,
  input wire logic [7:0] i_cur,
  input wire logic [7:0] i_mask,
  output logic o_used,
  output logic o_hit
);

  // ************************************************************
  // compare
  // ************************************************************
  // a disabled field always agrees, so it drops out of the match
  always_comb begin
    o_used = i_cmp[`ALM_FIELD_EN_BIT];
    o_hit = !o_used || ((i_cmp & i_mask) == (i_cur & i_mask));
  end

endmodule

// ===== rtc_alarm_backup_monitor.sv
// checker for the alarm and backup block, watching only its ports
// assumes register writes land only while o_bus_enable is high
`timescale 1ns/1ps
`include "rtc_alarm_regs.svh"
module rtc_alarm_backup_monitor
  import rtc_alarm_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire reg_req_s i_req,
  input wire rtc_time_s i_time,
  input wire logic i_tick_1hz,
  input wire supply_s i_supply,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic o_bus_enable,
  input wire logic o_mem_enable,
  input wire logic o_on_backup,
  input wire logic o_alarm_flag,
  input wire logic o_alarm_irq_b
);
  // ******
  // shadow registers
  // ******
  logic [1:0] cfg_q; // mode bits as last written
  logic [1:0] cfg_d;
  logic [7:0] ctl_q; // interrupt control as last written
  logic [7:0] ctl_d;
  logic [8:0] low_q; // cycles the interrupt has been low
  logic [8:0] low_d;
  logic wr_ok; // write that the block accepts

  assign wr_ok = i_req.wr & o_bus_enable;

  // next values; a refused write must not move the shadows
  always_comb begin
    cfg_d = cfg_q;
    ctl_d = ctl_q;
    if (wr_ok && i_req.addr == `ADDR_CONFIG) begin
      cfg_d = i_req.wdata[1:0];
    end
    if (wr_ok && i_req.addr == `ADDR_INT_CTRL) begin
      ctl_d = i_req.wdata;
    end
    low_d = o_alarm_irq_b ? 9'h000 : low_q + 9'h001;
  end

  // shadow flops
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      cfg_q <= `CONFIG_RST;
      ctl_q <= `INT_CTRL_RST;
      low_q <= 9'h000;
    end else begin
      cfg_q <= cfg_d;
      ctl_q <= ctl_d;
      low_q <= low_d;
    end
  end

  // ******
  // properties
  // ******
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_read_taken;
    i_req.rd && !i_req.wr && o_bus_enable;
  endsequence
  sequence s_pulse_end;
    $rose(o_alarm_irq_b) && ctl_q[7];
  endsequence

  AST_READ_ANSWER: assert property (s_read_taken |=> o_rvalid)
    else $error("read not answered");
  AST_NO_STRAY_ANSWER: assert property (o_rvalid |-> $past(i_req.rd && o_bus_enable))
    else $error("answer without accepted read");
  AST_LVR_BUS_OFF: assert property (i_supply.low_voltage_reset |=> !o_bus_enable && !o_mem_enable)
    else $error("bus alive below reset level");
  AST_MODE_A_BACKUP: assert property (!cfg_q[0] && i_supply.below_trip |=> o_on_backup && !o_bus_enable && !o_mem_enable)
    else $error("standard backup still reachable");
  AST_MODE_B_BUS: assert property (cfg_q == 2'h1 && !i_supply.low_voltage_reset |=> o_bus_enable && o_mem_enable)
    else $error("mode b access lost");
  AST_MODE_D_BUS: assert property (cfg_q == 2'h3 |=> o_bus_enable == !($past(i_supply.below_battery) || $past(i_supply.low_voltage_reset)))
    else $error("mode d access wrong");
  AST_BACKUP_SEL: assert property (cfg_q[0] |=> o_on_backup == $past(i_supply.below_battery))
    else $error("legacy switchover wrong");
  AST_FLAG_CAUSE: assert property ($rose(o_alarm_flag) |-> $past(i_tick_1hz) && $past(ctl_q[5]))
    else $error("flag set without enabled tick");
  AST_IRQ_FLAG: assert property ($fell(o_alarm_irq_b) |-> o_alarm_flag)
    else $error("interrupt without flag");
  AST_PULSE_LEN: assert property (s_pulse_end |-> low_q == 9'h0fa)
    else $error("pulse length wrong");
endmodule

bind rtc_alarm_backup rtc_alarm_backup_monitor i_mon (
  .i_clk_sys(i_clk_sys),
  .i_rst_b(i_rst_b),
  .i_req(i_req),
  .i_time(i_time),
  .i_tick_1hz(i_tick_1hz),
  .i_supply(i_supply),
  .o_rdata(o_rdata),
  .o_rvalid(o_rvalid),
  .o_bus_enable(o_bus_enable),
  .o_mem_enable(o_mem_enable),
  .o_on_backup(o_on_backup),
  .o_alarm_flag(o_alarm_flag),
  .o_alarm_irq_b(o_alarm_irq_b)
);

// ===== rtc_host_model.sv
// host model issuing register accesses to the alarm and backup block
// assumes the bench calls one task at a time, after reset release
`timescale 1ns/1ps
`include "rtc_alarm_regs.svh"
module rtc_host_model
  import rtc_alarm_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  output reg_req_s o_req
);
  // ******
  // access tasks
  // ******
  initial begin
    o_req = '0;
  end

  // one write strobe, launched and dropped on falling edges
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge i_clk_sys);
    o_req.addr = addr;
    o_req.wdata = data;
    o_req.wr = 1'b1;
    @(negedge i_clk_sys);
    o_req.wr = 1'b0;
    o_req.wdata = ~data; // released data must not look valid
  endtask

  // read strobe; answer is taken when the strobe drops
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    @(negedge i_clk_sys);
    o_req.addr = addr;
    o_req.rd = 1'b1;
    @(negedge i_clk_sys);
    o_req.rd = 1'b0;
    data = i_rdata;
    ok = i_rvalid;
  endtask

  // compares first, enable last, so no half-built alarm can fire
  task automatic load_alarm(input logic [7:0] c [6], input logic [7:0] ctl);
    for (int i = 0; i < 6; i++) begin
      write_reg(`ADDR_ALM_SEC + 8'(i), c[i]);
    end
    write_reg(`ADDR_INT_CTRL, ctl);
  endtask
endmodule

// ===== rtc_alarm_backup_tb.sv
// self-checking bench for the alarm and backup block
// assumes the host model owns the register port; the bench drives time and supply
`timescale 1ns/1ps
`include "rtc_alarm_regs.svh"
module rtc_alarm_backup_tb
  import rtc_alarm_pkg::*;
();
  logic clk;
  logic rst_b;
  reg_req_s req;
  rtc_time_s tm;
  logic tick;
  supply_s sup;
  logic [7:0] rdata;
  logic rvalid, bus_en, mem_en, on_bk, flag, irq_b;
  logic [7:0] rd;
  logic ok;
  int cnt;
  int n_errors = 0;
  int num_checks = 0;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  rtc_alarm_backup i_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_req(req), .i_time(tm),
    .i_tick_1hz(tick), .i_supply(sup), .o_rdata(rdata), .o_rvalid(rvalid),
    .o_bus_enable(bus_en), .o_mem_enable(mem_en), .o_on_backup(on_bk),
    .o_alarm_flag(flag), .o_alarm_irq_b(irq_b));
  rtc_host_model i_host (.i_clk_sys(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));

  // ******
  // helpers
  // ******
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    i_host.read_reg(a, rd, ok);
    chk1(ok, 1'b1);
    chk8(rd, e);
  endtask
  // new time and tick together, as the timekeeper shows them
  task automatic tick_at(input logic [47:0] t);
    @(negedge clk);
    tm = t;
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
  endtask
  // counts low cycles of the interrupt, bounded so a stuck line ends the run
  task automatic measure_low(output int n);
    n = 0;
    while (irq_b === 1'b0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n >= 300) begin
      n_errors++;
      summarize();
    end
  endtask
  // expected {on_backup, bus, mem} for a mode and supply state
  function automatic logic [2:0] exp_sup(input logic [1:0] c, input supply_s s);
    logic ob;
    logic en;
    ob = c[0] ? s.below_battery : s.below_trip;
    en = (c == 2'h1) ? 1'b1 : (c == 2'h3) ? !s.below_battery : !ob;
    en = en & !s.low_voltage_reset;
    return {ob, en, en};
  endfunction
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ******
  // sequence
  // ******
  initial begin
    rst_b = 1'b0;
    tick = 1'b0;
    sup = '0;
    tm = '0;
    repeat (12) @(negedge clk);
    chk1(flag, 1'b0);
    chk1(irq_b, 1'b1);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    rdchk(`ADDR_CONFIG, 8'h01);
    for (int i = 0; i < 6; i++) begin
      rdchk(`ADDR_ALM_SEC + 8'(i), 8'h00);
      i_host.write_reg(`ADDR_ALM_SEC + 8'(i), 8'h80 | 8'(i + 1));
      rdchk(`ADDR_ALM_SEC + 8'(i), 8'h80 | 8'(i + 1));
    end
    rdchk(8'h3f, 8'h00);
    // single event alarm on minutes, hours, date, month
    i_host.load_alarm('{8'h00, 8'hb0, 8'h91, 8'h81, 8'h81, 8'h00}, 8'h20);
    tick_at({8'h05, 8'h01, 8'h01, 8'h11, 8'h29, 8'h59});
    chk1(flag, 1'b0);
    tick_at({8'h05, 8'h01, 8'h01, 8'h11, 8'h30, 8'h00});
    chk1(flag, 1'b1);
    chk1(irq_b, 1'b0);
    repeat (300) @(negedge clk);
    chk1(irq_b, 1'b0);
    rdchk(`ADDR_STATUS, 8'h20);
    // writing the flag bit as one leaves the flag and the interrupt alone
    i_host.write_reg(`ADDR_STATUS, 8'h20);
    @(negedge clk);
    chk1(flag, 1'b1);
    chk1(irq_b, 1'b0);
    i_host.write_reg(`ADDR_STATUS, 8'h00);
    @(negedge clk);
    chk1(flag, 1'b0);
    chk1(irq_b, 1'b1);
    i_host.write_reg(`ADDR_INT_CTRL, 8'h00);
    tick_at({8'h05, 8'h01, 8'h01, 8'h11, 8'h30, 8'h00});
    chk1(flag, 1'b0);
    // pulse mode on seconds only, other fields disabled
    i_host.load_alarm('{8'hb0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 8'ha0);
    for (int k = 0; k < 2; k++) begin
      tick_at({8'h02, 8'h03, 8'h04, 8'h05, 8'(k + 1), 8'h30});
      chk1(irq_b, 1'b0);
      measure_low(cnt);
      chk8(8'(cnt), 8'hfa);
      chk1(flag, 1'b1);
    end
    i_host.write_reg(`ADDR_STATUS, 8'h00);
    // standard backup drops the alarm, legacy backup keeps it
    i_host.write_reg(`ADDR_CONFIG, 8'h00);
    sup.below_trip = 1'b1;
    repeat (2) @(negedge clk);
    tick_at({8'h02, 8'h03, 8'h04, 8'h05, 8'h09, 8'h30});
    chk1(flag, 1'b0);
    sup = '0;
    i_host.write_reg(`ADDR_CONFIG, 8'h01);
    sup.below_battery = 1'b1;
    repeat (2) @(negedge clk);
    tick_at({8'h02, 8'h03, 8'h04, 8'h05, 8'h10, 8'h30});
    chk1(flag, 1'b1);
    rdchk(`ADDR_CONFIG, 8'h01);
    measure_low(cnt);
    sup = '0;
    // every mode against every supply state
    for (int c = 0; c < 4; c++) begin
      i_host.write_reg(`ADDR_CONFIG, 8'(c));
      for (int s = 0; s < 8; s++) begin
        @(negedge clk);
        sup = supply_s'(s[2:0]);
        repeat (2) @(negedge clk);
        chk8({5'h00, on_bk, bus_en, mem_en}, {5'h00, exp_sup(c[1:0], sup)});
        sup = '0;
      end
    end
    // accesses below the reset level are refused
    sup.low_voltage_reset = 1'b1;
    repeat (2) @(negedge clk);
    i_host.write_reg(`ADDR_ALM_SEC, 8'h55);
    i_host.read_reg(`ADDR_ALM_SEC, rd, ok);
    chk1(ok, 1'b0);
    sup = '0;
    repeat (2) @(negedge clk);
    rdchk(`ADDR_ALM_SEC, 8'hb0);
    summarize();
  end
endmodule
